// *** sbsf_tap.sv ***
// Test access port controller for the burst memory
`timescale 1ns/10ps
`default_nettype none
module sbsf_tap
    import sbsf_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Filtered test pins
    input wire logic tck_f,
    input wire logic tms_f,
    input wire logic tdi_f,
    input wire logic trst_n_f,
    // Serial output
    output logic tdo_out,
    output logic tdo_oe
);
    sbsf_tap_t st_r, st_nxt;
    logic tck_d_r;
    logic rise, fall;
    logic [IR_W-1:0] ir_sh_r, ir_r;
    logic byp_r;

    assign rise = tck_f & ~tck_d_r;
    assign fall = ~tck_f & tck_d_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tck_d_r <= 1'b0;
        end else begin
            tck_d_r <= tck_f;
        end
    end

    // Controller walk
    always_comb begin
        case (st_r)
            T_RESET: st_nxt = tms_f ? T_RESET : T_IDLE;
            T_IDLE: st_nxt = tms_f ? T_SEL_DR : T_IDLE;
            T_SEL_DR: st_nxt = tms_f ? T_SEL_IR : T_CAP_DR;
            T_CAP_DR: st_nxt = tms_f ? T_EX1_DR : T_SH_DR;
            T_SH_DR: st_nxt = tms_f ? T_EX1_DR : T_SH_DR;
            T_EX1_DR: st_nxt = tms_f ? T_UP_DR : T_PA_DR;
            T_PA_DR: st_nxt = tms_f ? T_EX2_DR : T_PA_DR;
            T_EX2_DR: st_nxt = tms_f ? T_UP_DR : T_SH_DR;
            T_UP_DR: st_nxt = tms_f ? T_SEL_DR : T_IDLE;
            T_SEL_IR: st_nxt = tms_f ? T_RESET : T_CAP_IR;
            T_CAP_IR: st_nxt = tms_f ? T_EX1_IR : T_SH_IR;
            T_SH_IR: st_nxt = tms_f ? T_EX1_IR : T_SH_IR;
            T_EX1_IR: st_nxt = tms_f ? T_UP_IR : T_PA_IR;
            T_PA_IR: st_nxt = tms_f ? T_EX2_IR : T_PA_IR;
            T_EX2_IR: st_nxt = tms_f ? T_UP_IR : T_SH_IR;
            T_UP_IR: st_nxt = tms_f ? T_SEL_DR : T_IDLE;
            default: st_nxt = T_RESET;
        endcase
    end

    // State and shift paths on rising test clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= T_RESET;
            ir_sh_r <= IR_RST;
            ir_r <= IR_RST;
            byp_r <= 1'b0;
        end else if (!trst_n_f) begin
            st_r <= T_RESET;
            ir_r <= IR_RST;
        end else if (rise) begin
            st_r <= st_nxt;
            case (st_r)
                T_RESET: ir_r <= IR_RST;
                T_CAP_IR: ir_sh_r <= IR_CAPTURE;
                T_SH_IR: ir_sh_r <= {tdi_f, ir_sh_r[IR_W-1:1]};
                T_UP_IR: ir_r <= ir_sh_r;
                T_CAP_DR: byp_r <= 1'b0;
                T_SH_DR: byp_r <= tdi_f;
                default: byp_r <= byp_r;
            endcase
        end
    end

    // Output changes on falling test clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tdo_out <= 1'b0;
            tdo_oe <= 1'b0;
        end else if (fall) begin
            tdo_out <= (st_r == T_SH_IR) ? ir_sh_r[0] : byp_r;
            tdo_oe <= (st_r == T_SH_IR) || (st_r == T_SH_DR);
        end
    end
endmodule
`default_nettype wire

// *** sbsf_sram.sv ***
// Synchronous burst memory with flow-through reads and APB status
`timescale 1ns/10ps
`default_nettype none
package sbsf_pkg;
    // Data word layout
    localparam int LANES = 4;
    localparam int LANE_W = 8;
    localparam int PAR_BASE = 32;
    localparam int WORD_W = 36;
    localparam int BURST_W = 2;
    // Register offsets
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_STATUS = 12'h004;
    localparam logic [11:0] OFS_ADDR = 12'h008;
    // Control fields
    localparam int CTRL_SLEEP = 0;
    localparam logic CTRL_RST = 1'h0;
    // Status fields
    localparam int ST_ASLEEP = 0;
    localparam int ST_ACTIVE = 1;
    localparam int ST_ORDER = 2;
    localparam int ST_WRITE = 3;
    localparam int ST_CNT = 4;
    // Asynchronous input slots
    localparam int NASY = 6;
    localparam int IX_SLEEP = 0;
    localparam int IX_ORDER = 1;
    localparam int IX_TCK = 2;
    localparam int IX_TMS = 3;
    localparam int IX_TDI = 4;
    localparam int IX_TRST = 5;
    localparam logic [NASY-1:0] ASY_RST = 6'h38;
    // Test port instruction register
    localparam int IR_W = 4;
    localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
    localparam logic [IR_W-1:0] IR_RST = 4'hf;
    typedef enum logic [15:0] {
        T_RESET = 16'h0001, T_IDLE = 16'h0002,
        T_SEL_DR = 16'h0004, T_CAP_DR = 16'h0008,
        T_SH_DR = 16'h0010, T_EX1_DR = 16'h0020,
        T_PA_DR = 16'h0040, T_EX2_DR = 16'h0080,
        T_UP_DR = 16'h0100, T_SEL_IR = 16'h0200,
        T_CAP_IR = 16'h0400, T_SH_IR = 16'h0800,
        T_EX1_IR = 16'h1000, T_PA_IR = 16'h2000,
        T_EX2_IR = 16'h4000, T_UP_IR = 16'h8000
    } sbsf_tap_t;
endpackage

module sbsf_sram
    import sbsf_pkg::*;
#(
    parameter int ADDR_W = 17
)(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // Address and control
    input wire logic [ADDR_W-1:0] addr,
    input wire logic ctrl_addr_strobe_n,
    input wire logic proc_addr_strobe_n,
    input wire logic burst_advance_n,
    input wire logic chip_en_n,
    input wire logic chip_sel_hi,
    input wire logic chip_sel_lo_n,
    // Write control
    input wire logic global_write_n,
    input wire logic byte_write_gate_n,
    input wire logic [LANES-1:0] byte_sel_n,
    // Asynchronous controls
    input wire logic out_en_n,
    input wire logic burst_order_sel,
    input wire logic sleep_req,
    // Data pins
    input wire logic [WORD_W-1:0] dq_in,
    output logic [WORD_W-1:0] dq_out,
    output logic dq_oe,
    // Test port
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic trst_n,
    output logic tdo_out,
    output logic tdo_oe
);
    localparam int DEPTH = 1 << ADDR_W;

    // Pin synchronisers
    logic [NASY-1:0] asy_in;
    logic [NASY-1:0] s1_r, s2_r, s3_r, filt_r;

    // Control registers
    logic soft_sleep_r;
    logic asleep;

    // Access state
    logic active_r;
    logic [ADDR_W-1:0] base_r;
    logic [BURST_W-1:0] cnt_r;
    logic [ADDR_W-1:0] cur_addr;
    logic [BURST_W-1:0] low_bits;

    // Next access
    logic ads_c, ads_p, sel, load;
    logic nx_active;
    logic [ADDR_W-1:0] nx_base;
    logic [BURST_W-1:0] nx_cnt;
    logic [BURST_W-1:0] nx_low;
    logic [ADDR_W-1:0] nx_addr;
    logic [LANES-1:0] lanes;

    // Write stage
    logic wr_pend_r;
    logic wr_cyc_r;
    logic [ADDR_W-1:0] wr_addr_r;
    logic [WORD_W-1:0] wr_data_r;
    logic [LANES-1:0] wr_lanes_r;
    logic [WORD_W-1:0] in_mask;
    logic [WORD_W-1:0] merged;

    // Storage
    logic [WORD_W-1:0] mem_r [DEPTH];
    logic [WORD_W-1:0] rd_word;

    // APB
    logic [31:0] rd_val;
    logic rd_err;
    logic apb_done;

    assign asy_in = {trst_n, tdi, tms, tck, burst_order_sel, sleep_req};

    // Three-stage synchronisers with agreement filter
    for (genvar i = 0; i < NASY; i++) begin : g_sync
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                s1_r[i] <= ASY_RST[i];
                s2_r[i] <= ASY_RST[i];
                s3_r[i] <= ASY_RST[i];
                filt_r[i] <= ASY_RST[i];
            end else begin
                s1_r[i] <= asy_in[i];
                s2_r[i] <= s1_r[i];
                s3_r[i] <= s2_r[i];
                if (s2_r[i] == s3_r[i]) begin
                    filt_r[i] <= s3_r[i];
                end
            end
        end
    end

    // Internal clock gate for sleep
    assign asleep = filt_r[IX_SLEEP] | soft_sleep_r;

    // Burst address of the current access
    always_comb begin
        if (filt_r[IX_ORDER]) begin
            low_bits = base_r[BURST_W-1:0] ^ cnt_r;
        end else begin
            low_bits = base_r[BURST_W-1:0] + cnt_r;
        end
        cur_addr = {base_r[ADDR_W-1:BURST_W], low_bits};
    end

    // Decode of the cycle being sampled
    always_comb begin
        ads_c = ~ctrl_addr_strobe_n;
        ads_p = ~proc_addr_strobe_n & ~chip_en_n;
        sel = ~chip_en_n & chip_sel_hi & ~chip_sel_lo_n;
        load = ads_c | ads_p;
        nx_active = active_r;
        nx_base = base_r;
        nx_cnt = cnt_r;
        if (load) begin
            nx_active = sel;
            if (sel) begin
                nx_base = addr;
            end
            nx_cnt = '0;
        end else if (active_r && !burst_advance_n) begin
            nx_cnt = cnt_r + 1'b1;
        end
        if (filt_r[IX_ORDER]) begin
            nx_low = nx_base[BURST_W-1:0] ^ nx_cnt;
        end else begin
            nx_low = nx_base[BURST_W-1:0] + nx_cnt;
        end
        nx_addr = {nx_base[ADDR_W-1:BURST_W], nx_low};
        if (!global_write_n) begin
            lanes = '1;
        end else if (!byte_write_gate_n) begin
            lanes = ~byte_sel_n;
        end else begin
            lanes = '0;
        end
    end

    // Access sequencing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active_r <= 1'b0;
            base_r <= '0;
            cnt_r <= '0;
        end else if (!asleep) begin
            active_r <= nx_active;
            base_r <= nx_base;
            cnt_r <= nx_cnt;
        end
    end

    // Write capture; commit follows on the next edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_pend_r <= 1'b0;
            wr_cyc_r <= 1'b0;
            wr_addr_r <= '0;
            wr_data_r <= '0;
            wr_lanes_r <= '0;
        end else if (!asleep && nx_active && (|lanes)) begin
            wr_pend_r <= 1'b1;
            wr_cyc_r <= 1'b1;
            wr_addr_r <= nx_addr;
            wr_data_r <= dq_in;
            wr_lanes_r <= lanes;
        end else begin
            wr_pend_r <= 1'b0;
            wr_cyc_r <= 1'b0;
        end
    end

    // Lane mask: data byte plus its parity bit
    for (genvar b = 0; b < LANES; b++) begin : g_lane
        assign in_mask[b*LANE_W +: LANE_W] = {LANE_W{wr_lanes_r[b]}};
        assign in_mask[PAR_BASE+b] = wr_lanes_r[b];
    end

    assign merged = (mem_r[wr_addr_r] & ~in_mask) | (wr_data_r & in_mask);

    // Self-timed array write
    always_ff @(posedge pclk) begin
        if (wr_pend_r) begin
            mem_r[wr_addr_r] <= merged;
        end
    end

    // Flow-through read with forwarding of the pending write
    always_comb begin
        if (wr_pend_r && (wr_addr_r == cur_addr)) begin
            rd_word = merged;
        end else begin
            rd_word = mem_r[cur_addr];
        end
    end

    assign dq_out = rd_word;

    // Output enable acts without the clock
    assign dq_oe = ~out_en_n & active_r & ~wr_cyc_r & ~asleep
        & ~(|lanes);

    // Register read decode
    always_comb begin
        rd_val = '0;
        rd_err = 1'b0;
        case (paddr)
            OFS_CTRL: begin
                rd_val[CTRL_SLEEP] = soft_sleep_r;
            end
            OFS_STATUS: begin
                rd_val[ST_ASLEEP] = asleep;
                rd_val[ST_ACTIVE] = active_r;
                rd_val[ST_ORDER] = filt_r[IX_ORDER];
                rd_val[ST_WRITE] = wr_cyc_r;
                rd_val[ST_CNT +: BURST_W] = cnt_r;
            end
            OFS_ADDR: begin
                rd_val = 32'(cur_addr);
            end
            default: begin
                rd_err = 1'b1;
            end
        endcase
    end

    assign apb_done = psel & penable & pready;

    // APB answer one cycle into the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= '0;
            pslverr <= 1'b0;
        end else if (psel && penable && !pready) begin
            pready <= 1'b1;
            prdata <= pwrite ? 32'h0000_0000 : rd_val;
            pslverr <= rd_err;
        end else begin
            pready <= 1'b0;
            prdata <= '0;
            pslverr <= 1'b0;
        end
    end

    // Control register write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            soft_sleep_r <= CTRL_RST;
        end else if (apb_done && pwrite && (paddr == OFS_CTRL)) begin
            soft_sleep_r <= pwdata[CTRL_SLEEP];
        end
    end

    // Test access port
    sbsf_tap u_tap (
        .pclk(pclk),
        .presetn(presetn),
        .tck_f(filt_r[IX_TCK]),
        .tms_f(filt_r[IX_TMS]),
        .tdi_f(filt_r[IX_TDI]),
        .trst_n_f(filt_r[IX_TRST]),
        .tdo_out(tdo_out),
        .tdo_oe(tdo_oe)
    );
endmodule
`default_nettype wire

// *** sbsf_sram_checker.sv ***
// Concurrent checks on the burst memory port pins
`timescale 1ns/10ps
`default_nettype none
module sbsf_sram_checker
    import sbsf_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Bus pins
    input wire logic pready,
    input wire logic ctrl_addr_strobe_n,
    input wire logic proc_addr_strobe_n,
    input wire logic burst_advance_n,
    input wire logic chip_en_n,
    input wire logic chip_sel_hi,
    input wire logic chip_sel_lo_n,
    input wire logic global_write_n,
    input wire logic byte_write_gate_n,
    input wire logic out_en_n,
    input wire logic sleep_req,
    // Data pins
    input wire logic [WORD_W-1:0] dq_out,
    input wire logic dq_oe
);
    logic sel;
    logic no_wr;
    logic idle;
    assign sel = !chip_en_n & chip_sel_hi & !chip_sel_lo_n;
    assign no_wr = global_write_n & byte_write_gate_n;
    assign idle = ctrl_addr_strobe_n & no_wr & burst_advance_n & dq_oe;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_load;
        !ctrl_addr_strobe_n & sel & no_wr & !out_en_n & !sleep_req;
    endsequence
    sequence s_step;
        ctrl_addr_strobe_n & proc_addr_strobe_n & !burst_advance_n & no_wr
            & !out_en_n & !sleep_req;
    endsequence
    a_burst_drive: assert property (s_load ##1 s_step [*3] |-> dq_oe)
        else $error("Burst word not driven");
    a_oe_async: assert property (out_en_n |-> !dq_oe)
        else $error("Pins driven with output enable high");
    a_write_quiet: assert property (!global_write_n & !ctrl_addr_strobe_n & sel
        |=> !dq_oe)
        else $error("Pins driven in write cycle");
    a_desel_release: assert property (!ctrl_addr_strobe_n & !chip_sel_hi
        |=> !dq_oe)
        else $error("Pins driven after deselect");
    a_strobe_gated: assert property (idle & !proc_addr_strobe_n & chip_en_n
        |=> $stable(dq_out))
        else $error("Gated strobe loaded address");
    a_burst_hold: assert property (idle & proc_addr_strobe_n
        |=> $stable(dq_out))
        else $error("Counter moved without advance");
    a_sleep_quiet: assert property (sleep_req [*7] |-> !dq_oe)
        else $error("Pins driven while asleep");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("Ready longer than one cycle");
endmodule
bind sbsf_sram sbsf_sram_checker sbsf_sram_checker_inst (.pclk, .presetn,
    .pready, .ctrl_addr_strobe_n, .proc_addr_strobe_n, .burst_advance_n,
    .chip_en_n, .chip_sel_hi, .chip_sel_lo_n, .global_write_n,
    .byte_write_gate_n, .out_en_n, .sleep_req, .dq_out, .dq_oe);
`default_nettype wire

// *** sbsf_host_model.sv ***
// Processor side model that drives the burst memory bus
`timescale 1ns/10ps
`default_nettype none
module sbsf_host_model
    import sbsf_pkg::*;
(
    // Clock
    input wire logic pclk,
    // Address and control
    output logic [5:0] addr,
    output logic ctrl_addr_strobe_n,
    output logic proc_addr_strobe_n,
    output logic burst_advance_n,
    output logic chip_en_n,
    output logic chip_sel_hi,
    output logic chip_sel_lo_n,
    output logic global_write_n,
    output logic byte_write_gate_n,
    output logic [LANES-1:0] byte_sel_n,
    // Static and asynchronous controls
    output logic out_en_n,
    output logic burst_order_sel,
    output logic sleep_req,
    // Data driven toward the pins
    output logic [WORD_W-1:0] host_dq
);
    initial begin
        {ctrl_addr_strobe_n, proc_addr_strobe_n, burst_advance_n} = 3'h7;
        {chip_en_n, chip_sel_hi, chip_sel_lo_n} = 3'h2;
        {global_write_n, byte_write_gate_n, byte_sel_n} = 6'h3f;
        {out_en_n, burst_order_sel, sleep_req} = 3'h0;
        addr = 6'h00;
        host_dq = 36'h0;
    end
    // Kinds: 0 idle, 1 ctrl, 2 proc, 3 unselected, 4 proc gated off
    task op(input int s, input logic [5:0] a, input logic g, input logic b,
        input logic [3:0] m, input logic v, input logic [35:0] d);
        @(posedge pclk);
        ctrl_addr_strobe_n <= !(s == 1 || s == 3);
        proc_addr_strobe_n <= !(s == 2 || s == 4);
        chip_en_n <= (s == 4);
        chip_sel_hi <= (s != 3);
        addr <= a;
        burst_advance_n <= v;
        global_write_n <= g;
        byte_write_gate_n <= b;
        byte_sel_n <= m;
        host_dq <= (!g || !b) ? d : ~host_dq;
    endtask
    // Static pins change only while the bus is idle
    task pins(input logic o, input logic r, input logic z);
        @(posedge pclk);
        out_en_n <= o;
        burst_order_sel <= r;
        sleep_req <= z;
    endtask
endmodule
`default_nettype wire

// *** sbsf_sram_bench.sv ***
// Self-checking bench for the burst memory port
`timescale 1ns/10ps
`default_nettype none
module sbsf_sram_bench import sbsf_pkg::*;;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, dq_oe;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [5:0] addr, base;
    logic ctrl_addr_strobe_n, proc_addr_strobe_n, burst_advance_n, chip_en_n;
    logic chip_sel_hi, chip_sel_lo_n, global_write_n, byte_write_gate_n;
    logic out_en_n, burst_order_sel, sleep_req, tdo_out, tdo_oe;
    logic tck, tms, tdi, trst_n;
    logic [LANES-1:0] byte_sel_n;
    logic [WORD_W-1:0] host_dq, dq_in, dq_out, mem [64];
    logic [5:0] wt [4] = '{6'h2a, 6'h30, 6'h1f, 6'h0f};
    logic [1:0] cnt;
    logic act, wrc, slp, ord;
    int fail_count, samples_checked;
    assign dq_in = dq_oe ? dq_out : host_dq;
    sbsf_sram #(.ADDR_W(6)) sbsf_sram_inst (.pclk, .presetn, .psel,
        .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .addr,
        .ctrl_addr_strobe_n, .proc_addr_strobe_n, .burst_advance_n,
        .chip_en_n, .chip_sel_hi, .chip_sel_lo_n, .global_write_n,
        .byte_write_gate_n, .byte_sel_n, .out_en_n, .burst_order_sel,
        .sleep_req, .dq_in, .dq_out, .dq_oe, .tck, .tms, .tdi, .trst_n,
        .tdo_out, .tdo_oe);
    sbsf_host_model host_inst (.pclk, .addr, .ctrl_addr_strobe_n,
        .proc_addr_strobe_n, .burst_advance_n, .chip_en_n, .chip_sel_hi,
        .chip_sel_lo_n, .global_write_n, .byte_write_gate_n, .byte_sel_n,
        .out_en_n, .burst_order_sel, .sleep_req, .host_dq);
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    task check(input logic [35:0] seen, input logic [35:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [5:0] ea();
        return {base[5:2], ord ? base[1:0] ^ cnt : base[1:0] + cnt};
    endfunction
    function automatic logic [35:0] rnd();
        logic [63:0] r;
        r = {$urandom, $urandom};
        return r[35:0];
    endfunction
    task go(input int s, input logic [5:0] a, input logic g, input logic b,
        input logic [3:0] m, input logic v, input logic [35:0] d);
        logic [3:0] wl;
        host_inst.op(s, a, g, b, m, v, d);
        #1;
        wl = !g ? 4'hf : (!b ? ~m : 4'h0);
        check(dq_oe, act & !wrc & !slp & !out_en_n & (wl == 4'h0));
        if (act && !wrc && !slp) check(dq_out, mem[ea()]);
        wrc = 1'b0;
        if (!slp) begin
            if (s == 1 || s == 2) begin
                base = a;
                cnt = 2'h0;
                act = 1'b1;
            end else if (s == 3) begin
                act = 1'b0;
            end else if (act && !v) begin
                cnt = cnt + 2'h1;
            end
            if (act && wl != 4'h0) begin
                wrc = 1'b1;
                for (int i = 0; i < 4; i++) begin
                    if (wl[i]) mem[ea()][8*i+:8] = d[8*i+:8];
                    if (wl[i]) mem[ea()][32+i] = d[32+i];
                end
            end
        end
    endtask
    task rd4(input logic [5:0] a);
        go(1, a, 1, 1, 4'hf, 1, 36'h0);
        repeat (3) go(0, a, 1, 1, 4'hf, 0, 36'h0);
        repeat (2) go(0, a, 1, 1, 4'hf, 1, 36'h0);
    endtask
    task idle(input int n);
        repeat (n) host_inst.op(0, 6'h0, 1, 1, 4'hf, 1, 36'h0);
    endtask
    task tbit(input logic m, input logic d, input logic eo, input logic ev);
        tms <= m;
        tdi <= d;
        repeat (6) @(posedge pclk);
        tck <= 1'b1;
        repeat (6) @(posedge pclk);
        tck <= 1'b0;
        repeat (8) @(posedge pclk);
        check(tdo_oe, eo);
        if (eo) check(tdo_out, ev);
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
        input logic [31:0] er, input logic ee);
        int n;
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, wd};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        check(pready, 1'b1);
        if (!w) check(prdata, er);
        check(pslverr, ee);
        {psel, penable} <= 2'h0;
    endtask
    task conclude();
        if (fail_count == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #100000;
        fail_count++;
        conclude();
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = 48'h0;
        {tck, tms, tdi, trst_n} = 4'h7;
        {fail_count, samples_checked} = 64'h0;
        {act, wrc, slp, ord, cnt, base} = 12'h0;
        void'($urandom(32'hbfb20633));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, OFS_CTRL, 32'h0, 32'h0, 0);
        apb(1, OFS_CTRL, 32'h1, 32'h0, 0);
        apb(0, OFS_CTRL, 32'h0, 32'h1, 0);
        apb(0, 12'h00c, 32'h0, 32'h0, 1);
        apb(1, OFS_CTRL, 32'h0, 32'h0, 0);
        for (int r = 0; r < 2; r++) begin
            for (int k = 0; k < 4; k++) begin
                tbit(k == 1 || k == 2, 1'b1, 1'b0, 1'b0);
            end
            for (int k = 0; k < IR_W; k++) begin
                tbit(1'b0, 1'b1, 1'b1, IR_CAPTURE[k]);
            end
            tbit(1'b1, 1'b1, 1'b0, 1'b0);
            trst_n <= 1'b0;
            repeat (8) @(posedge pclk);
            trst_n <= 1'b1;
        end
        idle(8);
        for (int k = 0; k < 64; k += 4) begin
            go(1, k[5:0], 0, 1, 4'hf, 1, rnd());
            repeat (3) go(0, 6'h0, 0, 1, 4'hf, 0, rnd());
        end
        repeat (3) rd4(6'($urandom_range(63)));
        for (int k = 0; k < 4; k++) begin
            go(1, 6'h09, wt[k][5], wt[k][4], wt[k][3:0], 1, rnd());
            go(1, 6'h09, 1, 1, 4'hf, 1, 36'h0);
            go(0, 6'h09, 1, 1, 4'hf, 1, 36'h0);
        end
        go(2, 6'h11, 1, 1, 4'hf, 1, 36'h0);
        go(0, 6'h11, 1, 1, 4'hf, 0, 36'h0);
        go(4, 6'h22, 1, 1, 4'hf, 1, 36'h0);
        repeat (2) go(0, 6'h0, 1, 1, 4'hf, 1, 36'h0);
        host_inst.pins(1, 0, 0);
        #1;
        check(dq_oe, 1'b0);
        host_inst.pins(0, 0, 0);
        go(3, 6'h0, 1, 1, 4'hf, 1, 36'h0);
        go(0, 6'h0, 1, 1, 4'hf, 1, 36'h0);
        go(1, 6'h2d, 1, 1, 4'hf, 1, 36'h0);
        go(0, 6'h2d, 1, 1, 4'hf, 1, 36'h0);
        host_inst.pins(0, 1, 0);
        ord = 1'b1;
        idle(8);
        rd4(6'h2e);
        rd4(6'h13);
        host_inst.pins(0, 1, 1);
        idle(8);
        slp = 1'b1;
        go(1, 6'h05, 0, 1, 4'hf, 1, rnd());
        go(0, 6'h05, 1, 1, 4'hf, 1, 36'h0);
        apb(0, OFS_STATUS, 32'h0, {26'h0, cnt, 1'b0, ord, act, 1'b1}, 0);
        apb(0, OFS_ADDR, 32'h0, {26'h0, ea()}, 0);
        host_inst.pins(0, 1, 0);
        idle(8);
        slp = 1'b0;
        rd4(6'h05);
        conclude();
    end
endmodule
`default_nettype wire
